// file: dv/iers_seq_properties.sv
`timescale 1ns/1ps
// ********
// sequencer timing checks
// ********
module iers_seq_properties (
    // clock and reset
    input wire logic       clk,
    input wire logic       resetn,
    // core boundary
    input wire logic       instrDone,
    input wire logic       clearGieInstr,
    input wire logic       setGieInstr,
    input wire logic       returnFromHandlerInstr,
    input wire logic       sleeping,
    // redirect and stack
    input wire logic       coreStall,
    input wire logic       pcLoad,
    input wire logic       stackWe,
    input wire logic [7:0] statusFlagsReg,
    input wire logic [7:0] stackPtr
);
    logic afterRet_q;
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    // start of an entry or a return
    sequence entS;
        $rose(coreStall) && !$past(returnFromHandlerInstr) && !$past(sleeping);
    endsequence
    sequence retS;
        $rose(coreStall) && $past(returnFromHandlerInstr);
    endsequence
    // set by a return, cleared by the first retired instruction after it
    always_ff @(posedge clk) begin
        if (!resetn) begin
            afterRet_q <= 1'b0;
        end else if ($rose(coreStall) && $past(returnFromHandlerInstr)) begin
            afterRet_q <= 1'b1;
        end else if (instrDone && !coreStall) begin
            afterRet_q <= 1'b0;
        end
    end
    // assertions
    entry_timing_a: assert property (
        entS |-> ##1 stackWe ##1 stackWe ##1 !stackWe ##1 pcLoad && !coreStall)
        else $error("entry sequence timing wrong");
    entry_gie_a: assert property (entS |-> !statusFlagsReg[7])
        else $error("global enable not cleared on entry");
    entry_sp_a: assert property (entS |-> ##4 stackPtr == $past(stackPtr, 4) - 8'h02)
        else $error("stack pointer not lowered by two");
    take_gate_a: assert property (
        $rose(coreStall) && !$past(returnFromHandlerInstr) |-> $past(statusFlagsReg[7]))
        else $error("entry while global enable clear");
    clear_now_a: assert property (
        clearGieInstr && !returnFromHandlerInstr && !coreStall |=> !coreStall)
        else $error("entry on clear instruction");
    set_next_a: assert property (
        setGieInstr && !returnFromHandlerInstr && !coreStall |=> !coreStall)
        else $error("entry on set instruction");
    ret_timing_a: assert property (
        retS |-> ##4 pcLoad && statusFlagsReg[7] && stackPtr == $past(stackPtr, 4) + 8'h02)
        else $error("return sequence wrong");
    status_kept_a: assert property (
        coreStall && $past(coreStall) |-> $stable(statusFlagsReg[6:0]))
        else $error("status flags changed in sequence");
    one_after_ret_a: assert property (
        $rose(coreStall) && !$past(returnFromHandlerInstr) |-> !$past(afterRet_q))
        else $error("entry before an instruction after return");
    wake_extra_a: assert property (
        $rose(coreStall) && $past(sleeping) |-> !pcLoad[*8] ##1 pcLoad)
        else $error("wake entry timing wrong");
endmodule
bind iers_sequencer iers_seq_properties i_iers_seq_properties (
    .clk, .resetn, .instrDone, .clearGieInstr, .setGieInstr, .returnFromHandlerInstr,
    .sleeping, .coreStall, .pcLoad, .stackWe, .statusFlagsReg, .stackPtr
);

// file: dv/iers_sequencer_bench.sv
`timescale 1ns/1ps
// ********
// sequencer bench
// ********
module iers_sequencer_bench;
    typedef struct packed {
        logic [7:0] ev;
        logic [7:0] lvl;
        logic [7:0] en;
        logic [9:0] vec;
    } iers_row_t;
    logic       clk, resetn, clkEn, instrDone, clearGieInstr, setGieInstr, sleeping;
    logic       returnFromHandlerInstr, statusWr, coreStall, pcLoad, stackWe;
    logic [7:0] srcEvent, srcLevel, srcIsLevel, srcEnable, flagClrWr, flagOut, statusWrData;
    logic [7:0] statusFlagsReg, stackPtr, stackAddr, stackWData, stackRData;
    logic [9:0] nextPc, pcLoadValue;
    int         errorCnt, nCompared, cycles;
    iers_row_t  rows [5] = '{'{8'h01, 8'h00, 8'hff, 10'h001}, '{8'h80, 8'h00, 8'h80, 10'h008},
                            '{8'h24, 8'h00, 8'hff, 10'h003}, '{8'h00, 8'h40, 8'h40, 10'h007},
                            '{8'h10, 8'h00, 8'h10, 10'h005}};
    iers_sequencer i_iers_sequencer (
        .clk, .resetn, .clkEn, .srcEvent, .srcLevel, .srcIsLevel, .srcEnable, .flagClrWr,
        .flagOut, .instrDone, .nextPc, .clearGieInstr, .setGieInstr, .returnFromHandlerInstr,
        .statusWr, .statusWrData, .sleeping, .coreStall, .pcLoad, .pcLoadValue, .statusFlagsReg,
        .stackPtr, .stackWe, .stackAddr, .stackWData, .stackRData
    );
    iers_stack_mem i_iers_stack_mem (
        .clk(clk), .we(stackWe), .addr(stackAddr), .wData(stackWData), .rData(stackRData)
    );
    // clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        nCompared++;
        if (got !== exp) begin
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
            errorCnt++;
        end
    endtask
    // one cycle of core pulses: k = done, clear, set, return
    task automatic cyc(input logic [3:0] k, input logic [7:0] ev = 8'h00,
                       input logic sw = 1'b0, input logic [7:0] d = 8'h00,
                       input logic [7:0] clr = 8'h00);
        @(posedge clk);
        #1;
        {instrDone, clearGieInstr, setGieInstr, returnFromHandlerInstr} = k;
        srcEvent = ev;
        {statusWr, statusWrData} = {sw, d};
        flagClrWr = clr;
    endtask
    // edges until a pc redirect, 16 when none
    task automatic waitLoad(output int n);
        for (n = 1; n < 16; n++) begin
            cyc(4'h0);
            if (pcLoad === 1'b1) break;
        end
    endtask
    // retire one instruction and expect entry to vec
    task automatic enter(input logic [9:0] pc, input logic [9:0] vec, input logic [15:0] lat);
        logic [7:0] sp;
        int         n;
        sp = stackPtr;
        nextPc = pc;
        cyc(4'h8);
        waitLoad(n);
        chk("entry cycles", lat, 16'(n));
        chk("vector", 16'(vec), 16'(pcLoadValue));
        chk("gie", 16'h0000, 16'(statusFlagsReg[7]));
        chk("status kept", 16'h002b, 16'(statusFlagsReg[6:0]));
        chk("sp", 16'(sp - 8'h02), 16'(stackPtr));
        chk("push", {6'h00, pc}, {i_iers_stack_mem.mem[sp - 8'h01], i_iers_stack_mem.mem[sp]});
    endtask
    // return and expect resume at pc
    task automatic leave(input logic [9:0] pc);
        logic [7:0] sp;
        int         n;
        sp = stackPtr;
        cyc(4'h9);
        waitLoad(n);
        chk("return cycles", 16'h0005, 16'(n));
        chk("resume pc", 16'(pc), 16'(pcLoadValue));
        chk("gie back", 16'h0001, 16'(statusFlagsReg[7]));
        chk("sp pop", 16'(sp + 8'h02), 16'(stackPtr));
    endtask
    task automatic endSim();
        $display("compared %0d mismatches %0d", nCompared, errorCnt);
        if (errorCnt == 0 && nCompared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // cut a hang short
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            errorCnt++;
            endSim();
        end
    end
    // main sequence
    initial begin
        int n;
        {resetn, instrDone, clearGieInstr, setGieInstr, returnFromHandlerInstr} = '0;
        {statusWr, sleeping, srcEvent, srcLevel, srcEnable, flagClrWr, statusWrData} = '0;
        {clkEn, srcIsLevel, nextPc} = {1'b1, 8'h40, 10'h000};
        repeat (8) @(posedge clk);
        #1;
        resetn = 1'b1;
        chk("sp reset", 16'(iers_pkg::SP_RST), 16'(stackPtr));
        chk("status reset", 16'(iers_pkg::STATUS_RST), 16'(statusFlagsReg));
        chk("idle outputs", 16'h0000, 16'({flagOut, coreStall, pcLoad, stackWe}));
        foreach (rows[r]) begin
            srcEnable = rows[r].en;
            srcLevel = rows[r].lvl;
            cyc(4'h0, rows[r].ev, 1'b1, 8'hab);
            enter(10'h100 + 10'(r), rows[r].vec, 16'h0005);
            chk("flags", 16'(rows[r].ev & ~(8'h01 << (rows[r].vec - 10'h001))), 16'(flagOut));
            srcLevel = 8'h00;
            leave(10'h100 + 10'(r));
            cyc(4'h8, 8'h00, 1'b1, 8'h2b, 8'hff);
        end
        // disabled event stays pending, short level is lost
        srcEnable = 8'h00;
        srcLevel = 8'h40;
        cyc(4'h0, 8'h08, 1'b1, 8'hab);
        srcLevel = 8'h00;
        cyc(4'h8);
        waitLoad(n);
        chk("disabled take", 16'h0010, 16'(n));
        cyc(4'h0, 8'h00, 1'b0, 8'h00, 8'hf7);
        cyc(4'h0);
        chk("flag pending", 16'h0008, 16'(flagOut));
        srcEnable = 8'h48;
        enter(10'h200, 10'h004, 16'h0005);
        leave(10'h200);
        // clear blocks, set delays, nesting, one instruction after return
        srcEnable = 8'hff;
        cyc(4'h8, 8'h12);
        cyc(4'hc);
        waitLoad(n);
        chk("clear blocks", 16'h0010, 16'(n));
        chk("clear gie", 16'h0000, 16'(statusFlagsReg[7]));
        cyc(4'ha);
        enter(10'h300, 10'h002, 16'h0005);
        cyc(4'h8, 8'h00, 1'b1, 8'hab);
        enter(10'h301, 10'h005, 16'h0005);
        cyc(4'h0, 8'h01);
        leave(10'h301);
        cyc(4'h8);
        cyc(4'h0);
        chk("one after return", 16'h0000, 16'(coreStall));
        enter(10'h303, 10'h001, 16'h0005);
        leave(10'h303);
        leave(10'h300);
        // wake from sleep
        sleeping = 1'b1;
        cyc(4'h8, 8'h04);
        enter(10'h310, 10'h003, 16'h0009);
        sleeping = 1'b0;
        leave(10'h310);
        endSim();
    end
endmodule

// file: dv/iers_stack_mem.sv
`timescale 1ns/1ps
// ********
// stack memory, written on the edge, read at once
// ********
module iers_stack_mem (
    // clock
    input  wire logic       clk,
    // access port
    input  wire logic       we,
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wData,
    output logic      [7:0] rData
);
    logic [7:0] mem [256];
    // byte write
    always @(posedge clk) begin
        if (we) begin
            mem[addr] <= wData;
        end
    end
    assign rData = mem[addr]; // combinational read
endmodule

// file: hw/iers_pkg.sv
package iers_pkg;
    // ************************************************************
    // widths and sizes
    // ************************************************************
    localparam int unsigned NUM_SRC   = 8;   // interrupt sources
    localparam int unsigned PC_W      = 10;  // program counter width
    localparam int unsigned SP_W      = 8;   // stack pointer width
    localparam int unsigned VEC_W     = 4;   // vector index width
    localparam int unsigned CNT_W     = 3;   // sequence counter width
    // ************************************************************
    // field positions and reset values
    // ************************************************************
    localparam int unsigned GIE_BIT   = 7;   // global enable in status flags reg
    localparam logic [7:0]  STATUS_RST = 8'h00;
    localparam logic [SP_W-1:0] SP_RST = 8'hdf;
    localparam logic [PC_W-1:0] PC_RST = 10'h000;
    localparam logic [PC_W-1:0] VEC_BASE = 10'h001; // source 0 vector, after reset
    // ************************************************************
    // timing counts
    // ************************************************************
    localparam logic [CNT_W-1:0] ENTRY_CYC = 3'h4;  // entry cycles
    localparam logic [CNT_W-1:0] WAKE_CYC  = 3'h4;  // extra cycles from sleep
    localparam logic [CNT_W-1:0] RET_CYC   = 3'h4;  // return cycles
    localparam logic [SP_W-1:0]  PC_BYTES  = 8'h02; // bytes of pc on stack
    // ************************************************************
    // sequencer states
    // ************************************************************
    typedef enum logic [3:0] {
        ST_RUN   = 4'b0001,
        ST_WAKE  = 4'b0010,
        ST_ENTRY = 4'b0100,
        ST_RET   = 4'b1000
    } iers_state_t;
endpackage

// file: hw/iers_prio_arb.sv
`timescale 1ns/1ps
module iers_prio_arb (
    // request side
    iers_req_if.arb req
);
    // ************************************************************
    // fixed priority: lowest index wins
    // ************************************************************
    logic [iers_pkg::VEC_W-1:0] idx;
    logic                       found;
    // scan from the top so the lowest set bit is left last
    always_comb begin
        idx   = '0;
        found = 1'b0;
        for (int i = iers_pkg::NUM_SRC - 1; i >= 0; i--) begin
            if (req.pending[i]) begin
                idx   = iers_pkg::VEC_W'(i);
                found = 1'b1;
            end
        end
    end
    assign req.valid = found;
    assign req.index = idx;
endmodule

// file: hw/iers_req_if.sv
`timescale 1ns/1ps
interface iers_req_if;
    logic [iers_pkg::NUM_SRC-1:0] pending;
    logic                         valid;
    logic [iers_pkg::VEC_W-1:0]   index;
    modport arb (input pending, output valid, output index);
    modport seq (output pending, input valid, input index);
endinterface

// file: hw/iers_sequencer.sv
`timescale 1ns/1ps
module iers_sequencer (
    // clock and reset
    input  wire logic                           clk,
    input  wire logic                           resetn,
    input  wire logic                           clkEn,
    // interrupt sources
    input  wire logic [iers_pkg::NUM_SRC-1:0]   srcEvent,
    input  wire logic [iers_pkg::NUM_SRC-1:0]   srcLevel,
    input  wire logic [iers_pkg::NUM_SRC-1:0]   srcIsLevel,
    input  wire logic [iers_pkg::NUM_SRC-1:0]   srcEnable,
    input  wire logic [iers_pkg::NUM_SRC-1:0]   flagClrWr,
    output logic      [iers_pkg::NUM_SRC-1:0]   flagOut,
    // core instruction boundary
    input  wire logic                           instrDone,
    input  wire logic [iers_pkg::PC_W-1:0]      nextPc,
    input  wire logic                           clearGieInstr,
    input  wire logic                           setGieInstr,
    input  wire logic                           returnFromHandlerInstr,
    input  wire logic                           statusWr,
    input  wire logic [7:0]                     statusWrData,
    input  wire logic                           sleeping,
    // core redirect
    output logic                                coreStall,
    output logic                                pcLoad,
    output logic      [iers_pkg::PC_W-1:0]      pcLoadValue,
    output logic      [7:0]                     statusFlagsReg,
    output logic      [iers_pkg::SP_W-1:0]      stackPtr,
    // stack memory
    output logic                                stackWe,
    output logic      [iers_pkg::SP_W-1:0]      stackAddr,
    output logic      [7:0]                     stackWData,
    input  wire logic [7:0]                     stackRData
);
    // ************************************************************
    // state and storage
    // ************************************************************
    iers_pkg::iers_state_t      state_q;
    logic [iers_pkg::CNT_W-1:0] cnt_q;
    logic [iers_pkg::NUM_SRC-1:0] flag_q;
    logic [iers_pkg::NUM_SRC-1:0] taken_q;
    logic [7:0]                 status_q;
    logic [iers_pkg::SP_W-1:0]  sp_q;
    logic [iers_pkg::PC_W-1:0]  retPc_q;
    logic [iers_pkg::PC_W-1:0]  popPc_q;
    logic [iers_pkg::VEC_W-1:0] vec_q;
    logic                       holdOff_q;
    logic                       pcLoad_q;
    logic [iers_pkg::PC_W-1:0]  pcLoadValue_q;
    logic                       stackWe_q;
    logic [iers_pkg::SP_W-1:0]  stackAddr_q;
    logic [7:0]                 stackWData_q;
    logic                       gieEff;
    logic                       accept;
    logic [iers_pkg::NUM_SRC-1:0] request;
    logic [iers_pkg::NUM_SRC-1:0] oneHot;
    iers_req_if reqBus ();

    // ************************************************************
    // request gating and arbitration
    // ************************************************************
    // clear-global-enable in this cycle blocks acceptance at once
    assign gieEff = status_q[iers_pkg::GIE_BIT] & ~clearGieInstr;
    // level sources need no flag; event sources use their flag
    assign request = ((srcIsLevel & srcLevel) | (~srcIsLevel & flag_q))
                     & srcEnable;
    assign reqBus.pending = request & {iers_pkg::NUM_SRC{gieEff}};
    iers_prio_arb uArb (
        .req (reqBus)
    );
    // accept only at a boundary: not on a return or set-enable, nor right after return
    assign accept = (state_q == iers_pkg::ST_RUN) & instrDone & reqBus.valid
                    & ~holdOff_q & ~setGieInstr & ~returnFromHandlerInstr;
    assign oneHot = iers_pkg::NUM_SRC'(1) << reqBus.index;

    // ************************************************************
    // event flags
    // ************************************************************
    // hardware set wins over software clear and over vector clear
    generate
        for (genvar g = 0; g < iers_pkg::NUM_SRC; g++) begin : gFlag
            always_ff @(posedge clk) begin
                if (!resetn) begin
                    flag_q[g] <= 1'b0;
                end else if (clkEn) begin
                    if (srcEvent[g] && !srcIsLevel[g]) begin
                        flag_q[g] <= 1'b1;
                    end else if (flagClrWr[g]) begin
                        flag_q[g] <= 1'b0;
                    end else if (accept && oneHot[g]) begin
                        flag_q[g] <= 1'b0;
                    end
                end
            end
        end
    endgenerate
    assign flagOut = flag_q;

    // ************************************************************
    // sequencer state machine
    // ************************************************************
    // entry counts four cycles, preceded by four wake cycles if asleep
    always_ff @(posedge clk) begin
        if (!resetn) begin
            state_q <= iers_pkg::ST_RUN;
            cnt_q   <= '0;
            vec_q   <= '0;
            taken_q <= '0;
        end else if (clkEn) begin
            case (state_q)
                iers_pkg::ST_RUN: begin
                    if (accept) begin
                        vec_q   <= reqBus.index;
                        taken_q <= oneHot;
                        cnt_q   <= '0;
                        state_q <= sleeping ? iers_pkg::ST_WAKE
                                            : iers_pkg::ST_ENTRY;
                    end else if (returnFromHandlerInstr && instrDone) begin
                        cnt_q   <= '0;
                        state_q <= iers_pkg::ST_RET;
                    end
                end
                iers_pkg::ST_WAKE: begin
                    if (cnt_q == iers_pkg::WAKE_CYC - 3'h1) begin
                        cnt_q   <= '0;
                        state_q <= iers_pkg::ST_ENTRY;
                    end else begin
                        cnt_q <= cnt_q + 3'h1;
                    end
                end
                iers_pkg::ST_ENTRY: begin
                    if (cnt_q == iers_pkg::ENTRY_CYC - 3'h1) begin
                        cnt_q   <= '0;
                        state_q <= iers_pkg::ST_RUN;
                    end else begin
                        cnt_q <= cnt_q + 3'h1;
                    end
                end
                iers_pkg::ST_RET: begin
                    if (cnt_q == iers_pkg::RET_CYC - 3'h1) begin
                        cnt_q   <= '0;
                        state_q <= iers_pkg::ST_RUN;
                    end else begin
                        cnt_q <= cnt_q + 3'h1;
                    end
                end
                default: begin
                    state_q <= iers_pkg::ST_RUN;
                    cnt_q   <= '0;
                end
            endcase
        end
    end

    // ************************************************************
    // hold-off after return; set-global-enable only blocks acceptance in its own cycle
    // ************************************************************
    // one main-program instruction must retire before the next entry
    always_ff @(posedge clk) begin
        if (!resetn) begin
            holdOff_q <= 1'b0;
        end else if (clkEn) begin
            if (state_q == iers_pkg::ST_RET && cnt_q == iers_pkg::RET_CYC - 3'h1) begin
                holdOff_q <= 1'b1;
            end else if (state_q == iers_pkg::ST_RUN && instrDone) begin
                holdOff_q <= 1'b0;
            end
        end
    end

    // ************************************************************
    // status flags register, global enable
    // ************************************************************
    // only the enable bit is touched by entry and return
    always_ff @(posedge clk) begin
        if (!resetn) begin
            status_q <= iers_pkg::STATUS_RST;
        end else if (clkEn) begin
            if (accept) begin
                status_q[iers_pkg::GIE_BIT] <= 1'b0;
            end else if (state_q == iers_pkg::ST_RET
                         && cnt_q == iers_pkg::RET_CYC - 3'h1) begin
                status_q[iers_pkg::GIE_BIT] <= 1'b1;
            end else if (clearGieInstr) begin
                status_q[iers_pkg::GIE_BIT] <= 1'b0;
            end else if (setGieInstr) begin
                status_q[iers_pkg::GIE_BIT] <= 1'b1;
            end else if (statusWr) begin
                status_q <= statusWrData;
            end
        end
    end
    assign statusFlagsReg = status_q;

    // ************************************************************
    // stack pointer and return address
    // ************************************************************
    // push low byte at sp, high byte at sp-1; pop in reverse
    always_ff @(posedge clk) begin
        if (!resetn) begin
            sp_q    <= iers_pkg::SP_RST;
            retPc_q <= iers_pkg::PC_RST;
            popPc_q <= iers_pkg::PC_RST;
        end else if (clkEn) begin
            if (accept) begin
                retPc_q <= nextPc;
            end
            if (state_q == iers_pkg::ST_ENTRY
                && cnt_q == iers_pkg::ENTRY_CYC - 3'h1) begin
                sp_q <= sp_q - iers_pkg::PC_BYTES;
            end
            if (state_q == iers_pkg::ST_RET && cnt_q == 3'h1) begin
                popPc_q[iers_pkg::PC_W-1:8] <= stackRData[iers_pkg::PC_W-9:0];
            end
            if (state_q == iers_pkg::ST_RET && cnt_q == 3'h2) begin
                popPc_q[7:0] <= stackRData;
            end
            if (state_q == iers_pkg::ST_RET
                && cnt_q == iers_pkg::RET_CYC - 3'h1) begin
                sp_q <= sp_q + iers_pkg::PC_BYTES;
            end
        end
    end
    assign stackPtr = sp_q;

    // ************************************************************
    // stack port and pc redirect
    // ************************************************************
    // registered stack access: writes during entry, read addresses in return
    always_ff @(posedge clk) begin
        if (!resetn) begin
            stackWe_q     <= 1'b0;
            stackAddr_q   <= iers_pkg::SP_RST;
            stackWData_q  <= 8'h00;
            pcLoad_q      <= 1'b0;
            pcLoadValue_q <= iers_pkg::PC_RST;
        end else if (clkEn) begin
            stackWe_q <= 1'b0;
            pcLoad_q  <= 1'b0;
            if (state_q == iers_pkg::ST_ENTRY && cnt_q == 3'h0) begin
                stackWe_q    <= 1'b1;
                stackAddr_q  <= sp_q;
                stackWData_q <= retPc_q[7:0];
            end else if (state_q == iers_pkg::ST_ENTRY && cnt_q == 3'h1) begin
                stackWe_q    <= 1'b1;
                stackAddr_q  <= sp_q - 8'h01;
                stackWData_q <= {6'h00, retPc_q[iers_pkg::PC_W-1:8]};
            end else if (state_q == iers_pkg::ST_RET && cnt_q == 3'h0) begin
                stackAddr_q <= sp_q + 8'h01;
            end else if (state_q == iers_pkg::ST_RET && cnt_q == 3'h1) begin
                stackAddr_q <= sp_q + iers_pkg::PC_BYTES;
            end
            if (state_q == iers_pkg::ST_ENTRY
                && cnt_q == iers_pkg::ENTRY_CYC - 3'h1) begin
                pcLoad_q      <= 1'b1;
                pcLoadValue_q <= iers_pkg::VEC_BASE
                                 + iers_pkg::PC_W'(vec_q);
            end else if (state_q == iers_pkg::ST_RET
                         && cnt_q == iers_pkg::RET_CYC - 3'h1) begin
                pcLoad_q      <= 1'b1;
                pcLoadValue_q <= popPc_q;
            end
        end
    end
    assign stackWe     = stackWe_q;
    assign stackAddr   = stackAddr_q;
    assign stackWData  = stackWData_q;
    assign pcLoad      = pcLoad_q;
    assign pcLoadValue = pcLoadValue_q;
    // core is held while a sequence runs
    assign coreStall = (state_q != iers_pkg::ST_RUN);
endmodule
